// ### i2c_led_gpio_expander.sv
// eight-port expander with blink, pwm dimming and transition interrupt
// assumes pins are asynchronous; i_link_clk oversamples the serial bus
`timescale 1ns/100ps
module i2c_led_gpio_expander (
  // clocks and reset
  input  wire logic       i_clk,
  input  wire logic       i_link_clk,
  input  wire logic       i_sys_rst,
  // serial bus
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output wire logic       o_sda_out,
  output wire logic       o_sda_oe,
  // address select pins
  input  wire logic       i_addr_select_pin_0,
  input  wire logic       i_addr_select_pin_1,
  input  wire logic       i_addr_select_pin_2,
  // port pins
  input  wire logic [7:0] i_io_port_pins,
  output wire logic [7:0] o_io_port_pins_out,
  output wire logic [7:0] o_io_port_pins_oe,
  // ninth pin
  output wire logic       o_irq_or_ninth_output_pin_out,
  output wire logic       o_irq_or_ninth_output_pin_oe,
  // status
  output wire logic       o_standby,
  output wire logic       o_osc_running
);
  import gpio_exp_pkg::*;

  // link domain: synchronisers, [0] feeds only [1]
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic [2:0]  ad_meta_reg;
  logic [2:0]  ad_sync_reg;
  logic [7:0]  pin_meta_l_reg;
  logic [7:0]  pin_sync_l_reg;
  logic [2:0]  neq_scl_reg;
  logic [2:0]  neq_sda_reg;
  i2c_state_e  state_reg;
  i2c_state_e  ack_next_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  ptr_reg;
  logic        sda_oe_reg;
  logic        busy_reg;
  logic        nack_reg;
  logic        rd_tgl_reg;
  cfg_s        cfg_l_reg;
  cfg_s        xfer_reg;
  logic        pend_reg;
  logic        req_tgl_reg;
  logic        ack_meta_reg;
  logic        ack_sync_reg;
  logic        req_seen_reg;
  logic        scl;
  logic        sda;
  logic        start_det;
  logic        stop_det;
  logic        scl_rise;
  logic        scl_fall;
  logic [6:0]  my_addr;
  logic        wr_strobe;
  logic        load_rd;
  logic        launch;
  logic [7:0]  rd_data;

  assign scl       = scl_sync_reg[1];
  assign sda       = sda_sync_reg[1];
  assign start_det = scl && scl_sync_reg[2] && sda_sync_reg[2] && !sda;
  assign stop_det  = scl && scl_sync_reg[2] && !sda_sync_reg[2] && sda;
  assign scl_rise  = scl && !scl_sync_reg[2];
  assign scl_fall  = !scl && scl_sync_reg[2];

  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      scl_sync_reg   <= 3'h7;
      sda_sync_reg   <= 3'h7;
      // idle high like the bus, so no strap looks unlike a bus line
      ad_meta_reg    <= 3'h7;
      ad_sync_reg    <= 3'h7;
      pin_meta_l_reg <= 8'h00;
      pin_sync_l_reg <= 8'h00;
    end else begin
      scl_sync_reg   <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg   <= {sda_sync_reg[1:0], i_sda};
      ad_meta_reg    <= {i_addr_select_pin_2, i_addr_select_pin_1,
                         i_addr_select_pin_0};
      ad_sync_reg    <= ad_meta_reg;
      pin_meta_l_reg <= i_io_port_pins;
      pin_sync_l_reg <= pin_meta_l_reg;
    end
  end

  // a pin is bus-tied until it is seen to differ from that line
  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      neq_scl_reg <= 3'h0;
      neq_sda_reg <= 3'h0;
    end else begin
      neq_scl_reg <= neq_scl_reg | (ad_sync_reg ^ {3{scl}});
      neq_sda_reg <= neq_sda_reg | (ad_sync_reg ^ {3{sda}});
    end
  end

  function automatic pin_class_t classify(input int k);
    if (!neq_scl_reg[k])
      classify = PIN_SCL;
    else if (!neq_sda_reg[k])
      classify = PIN_SDA;
    else
      classify = ad_sync_reg[k] ? PIN_VCC : PIN_GND;
  endfunction

  // address from pin classes
  // always_comb also follows the registers read inside classify
  always_comb begin
    my_addr = addr_map(classify(2), classify(1), classify(0));
  end

  always_comb begin
    rd_data = 8'h00;
    case (ptr_reg)
      REG_INPUT:  rd_data = pin_sync_l_reg;
      REG_PHASE0: rd_data = cfg_l_reg.phase0;
      REG_DIR:    rd_data = cfg_l_reg.dir;
      REG_PWM_EN: rd_data = cfg_l_reg.pwm_en;
      REG_GLOBAL: rd_data = cfg_l_reg.glob_duty;
      REG_PHASE1: rd_data = cfg_l_reg.phase1;
      REG_MASTER: rd_data = {4'h0, cfg_l_reg.master};
      REG_CONFIG: rd_data = cfg_l_reg.ctrl;
      default: begin
        if (ptr_reg >= REG_INTENS_BASE && ptr_reg <= REG_INTENS_LAST)
          rd_data = cfg_l_reg.intens[ptr_reg[1:0]*8 +: 8];
      end
    endcase
  end

  assign wr_strobe = scl_fall && state_reg == ST_WR && bit_cnt_reg == 4'h8;
  assign load_rd   = scl_fall &&
                     ((state_reg == ST_ACK && ack_next_reg == ST_RD) ||
                      (state_reg == ST_MACK && !nack_reg));

  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg    <= ST_IDLE;
      ack_next_reg <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      ptr_reg      <= 8'h00;
      sda_oe_reg   <= 1'b0;
      busy_reg     <= 1'b0;
      nack_reg     <= 1'b0;
    end else if (start_det) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'b0;
      busy_reg    <= 1'b1;
    end else if (stop_det) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      if (scl_rise) begin
        // receive states only: the byte stays whole through its ack
        if (state_reg inside {ST_ADDR, ST_CMD, ST_WR})
          shift_reg <= {shift_reg[6:0], sda};
        nack_reg    <= sda;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == my_addr) begin
                sda_oe_reg   <= 1'b1;
                state_reg    <= ST_ACK;
                ack_next_reg <= shift_reg[0] ? ST_RD : ST_CMD;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_CMD, ST_WR: begin
            if (bit_cnt_reg == 4'h8) begin
              ptr_reg      <= (state_reg == ST_CMD) ? shift_reg
                                                    : ptr_reg + 8'h01;
              sda_oe_reg   <= 1'b1;
              state_reg    <= ST_ACK;
              ack_next_reg <= ST_WR;
            end
          end
          ST_ACK, ST_MACK: begin
            bit_cnt_reg <= 4'h0;
            if (load_rd) begin
              tx_reg     <= rd_data;
              sda_oe_reg <= !rd_data[7];
              ptr_reg    <= ptr_reg + 8'h01;
              state_reg  <= ST_RD;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= (state_reg == ST_ACK) ? ack_next_reg : ST_IDLE;
            end
          end
          ST_RD: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_MACK;
            end else begin
              tx_reg     <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= !tx_reg[6];
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // each input read marks a snapshot
  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      rd_tgl_reg <= 1'b0;
    else if (load_rd && ptr_reg == REG_INPUT && !start_det && !stop_det)
      rd_tgl_reg <= !rd_tgl_reg;
  end

  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg_l_reg <= CFG_RST;
    end else if (wr_strobe && !start_det && !stop_det) begin
      case (ptr_reg)
        REG_PHASE0: cfg_l_reg.phase0    <= shift_reg;
        REG_DIR:    cfg_l_reg.dir       <= shift_reg;
        REG_PWM_EN: cfg_l_reg.pwm_en    <= shift_reg;
        REG_GLOBAL: cfg_l_reg.glob_duty <= shift_reg;
        REG_PHASE1: cfg_l_reg.phase1    <= shift_reg;
        REG_MASTER: cfg_l_reg.master    <= shift_reg[3:0];
        REG_CONFIG: cfg_l_reg.ctrl      <= shift_reg & CFG_MASK;
        default: begin
          if (ptr_reg >= REG_INTENS_BASE && ptr_reg <= REG_INTENS_LAST)
            cfg_l_reg.intens[ptr_reg[1:0]*8 +: 8] <= shift_reg;
        end
      endcase
    end
  end

  // configuration crosses as a whole word by req/ack toggles;
  // a write during a crossing stays pending and is sent next
  assign launch = pend_reg && (req_tgl_reg == ack_sync_reg);

  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_reg     <= 1'b0;
      req_tgl_reg  <= 1'b0;
      xfer_reg     <= CFG_RST;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      pend_reg     <= wr_strobe || (pend_reg && !launch);
      ack_sync_reg <= ack_meta_reg;
      ack_meta_reg <= req_seen_reg;
      if (launch) begin
        xfer_reg    <= cfg_l_reg;
        req_tgl_reg <= !req_tgl_reg;
      end
    end
  end

  // system domain
  logic        req_meta_reg;
  logic        req_sync_reg;
  logic        rd_meta_reg;
  logic        rd_sync_reg;
  logic        rd_seen_reg;
  logic        busy_meta_reg;
  logic        busy_sync_reg;
  cfg_s        cfg_reg;
  logic [7:0]  in_meta_reg;
  logic [7:0]  in_sync_reg;
  logic [7:0]  snap_reg;
  logic [2:0]  init_reg;
  logic        irq_pending_reg;
  logic [11:0] osc_div_reg;
  logic [7:0]  pwm_cnt_reg;
  logic [7:0]  port_oe_reg;
  logic        ninth_oe_reg;
  logic        standby_reg;
  logic        rd_event;
  logic        pwm_any;
  logic        osc_tick;
  logic [7:0]  lvl;
  logic        o8_lvl;
  logic [7:0]  pwm_on;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_meta_reg  <= 1'b0;
      req_sync_reg  <= 1'b0;
      req_seen_reg  <= 1'b0;
      rd_meta_reg   <= 1'b0;
      rd_sync_reg   <= 1'b0;
      rd_seen_reg   <= 1'b0;
      busy_meta_reg <= 1'b0;
      busy_sync_reg <= 1'b0;
      in_meta_reg   <= 8'h00;
      in_sync_reg   <= 8'h00;
      cfg_reg       <= CFG_RST;
    end else begin
      req_meta_reg  <= req_tgl_reg;
      req_sync_reg  <= req_meta_reg;
      req_seen_reg  <= req_sync_reg;
      rd_meta_reg   <= rd_tgl_reg;
      rd_sync_reg   <= rd_meta_reg;
      rd_seen_reg   <= rd_sync_reg;
      busy_meta_reg <= busy_reg;
      busy_sync_reg <= busy_meta_reg;
      in_meta_reg   <= i_io_port_pins;
      in_sync_reg   <= in_meta_reg;
      if (req_sync_reg != req_seen_reg)
        cfg_reg <= xfer_reg;
    end
  end

  assign rd_event = rd_sync_reg ^ rd_seen_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      init_reg        <= 3'h7;
      snap_reg        <= 8'h00;
      irq_pending_reg <= 1'b0;
    end else begin
      // hold off until the pin synchroniser carries real levels
      init_reg <= {init_reg[1:0], 1'b0};
      if (init_reg[2] || rd_event)
        snap_reg <= in_sync_reg;
      irq_pending_reg <= !init_reg[2] && !rd_event &&
                         (|((in_sync_reg ^ snap_reg) & cfg_reg.dir));
    end
  end

  // oscillator only runs with pwm in use
  assign pwm_any  = |cfg_reg.pwm_en;
  assign osc_tick = pwm_any && osc_div_reg == OSC_DIV_LAST;

  // about 32 kHz pwm time base
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      osc_div_reg <= 12'h000;
      pwm_cnt_reg <= 8'h00;
    end else if (!pwm_any) begin
      osc_div_reg <= 12'h000;
      pwm_cnt_reg <= 8'h00;
    end else if (osc_tick) begin
      osc_div_reg <= 12'h000;
      pwm_cnt_reg <= (pwm_cnt_reg == PWM_LAST) ? 8'h00 : pwm_cnt_reg + 8'h01;
    end else begin
      osc_div_reg <= osc_div_reg + 12'h001;
    end
  end

  function automatic logic [7:0] on_ticks(input int i);
    logic [7:0] m;
    logic [7:0] n;
    m = {4'h0, cfg_reg.master};
    n = {4'h0, cfg_reg.intens[i*4 +: 4]};
    if (cfg_reg.ctrl[CFG_GLOBAL])
      on_ticks = (cfg_reg.glob_duty > PWM_FULL) ? PWM_FULL
                                                 : cfg_reg.glob_duty;
    else
      on_ticks = 8'(m * n);
  endfunction

  always_comb begin
    pwm_on = 8'h00;
    for (int i = 0; i < 8; i++)
      pwm_on[i] = pwm_cnt_reg < on_ticks(i);
  end

  assign lvl    = (cfg_reg.ctrl[CFG_BLINK_EN] && cfg_reg.ctrl[CFG_BLINK_FLIP])
                  ? cfg_reg.phase1 : cfg_reg.phase0;
  assign o8_lvl = (cfg_reg.ctrl[CFG_BLINK_EN] && cfg_reg.ctrl[CFG_BLINK_FLIP])
                  ? cfg_reg.ctrl[CFG_O8_PH1] : cfg_reg.ctrl[CFG_O8_PH0];

  // registered drive keeps static outputs glitch free
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      port_oe_reg  <= 8'h00;
      ninth_oe_reg <= 1'b0;
      standby_reg  <= 1'b0;
    end else begin
      port_oe_reg  <= ~cfg_reg.dir & ~lvl & (~cfg_reg.pwm_en | pwm_on);
      ninth_oe_reg <= cfg_reg.ctrl[CFG_IRQ_MODE] ? irq_pending_reg : !o8_lvl;
      standby_reg  <= !busy_sync_reg && !pwm_any;
    end
  end

  assign o_sda_out                     = 1'b0;
  assign o_sda_oe                      = sda_oe_reg;
  assign o_io_port_pins_out            = 8'h00;
  assign o_io_port_pins_oe             = port_oe_reg;
  assign o_irq_or_ninth_output_pin_out = 1'b0;
  assign o_irq_or_ninth_output_pin_oe  = ninth_oe_reg;
  assign o_standby                     = standby_reg;
  assign o_osc_running                 = pwm_any;

  a_dir_reset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $past(i_sys_rst) |-> cfg_reg.dir == 8'hff && port_oe_reg == 8'h00)
    else $error("ports not inputs after reset");
  a_irq_change: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!init_reg[2] && !rd_event && cfg_reg.ctrl[CFG_IRQ_MODE] &&
     |((in_sync_reg ^ snap_reg) & cfg_reg.dir)) |=> ##1 ninth_oe_reg)
    else $error("input change did not raise interrupt");
  a_irq_read_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rd_event |=> !irq_pending_reg && snap_reg == $past(in_sync_reg))
    else $error("input read did not clear interrupt");
  a_blink_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!cfg_reg.ctrl[CFG_BLINK_EN] && !pwm_any) |=>
      port_oe_reg == $past(~cfg_reg.dir & ~cfg_reg.phase0))
    else $error("outputs not following phase 0");
  a_blink_flip: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cfg_reg.ctrl[CFG_BLINK_EN] && cfg_reg.ctrl[CFG_BLINK_FLIP] && !pwm_any)
      |=> port_oe_reg == $past(~cfg_reg.dir & ~cfg_reg.phase1))
    else $error("flip did not select phase 1");
  a_osc_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !pwm_any |=> osc_div_reg == 12'h000 && pwm_cnt_reg == 8'h00)
    else $error("oscillator running without pwm");
  a_master_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cfg_reg.pwm_en[0] && !cfg_reg.ctrl[CFG_GLOBAL] &&
     cfg_reg.master == 4'h0) |=> !port_oe_reg[0])
    else $error("zero master still drives");
  a_pwm_wrap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (osc_tick && pwm_cnt_reg == PWM_LAST) |=> pwm_cnt_reg == 8'h00)
    else $error("pwm period is not 240 steps");
  a_standby: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!busy_sync_reg && !pwm_any) ##1 (!busy_sync_reg && !pwm_any) |-> o_standby)
    else $error("standby not entered");
  a_addr_ack: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
    (scl_fall && !start_det && !stop_det && state_reg == ST_ADDR &&
     bit_cnt_reg == 4'h8 && shift_reg[7:1] == my_addr)
      |=> sda_oe_reg && state_reg == ST_ACK)
    else $error("address not acknowledged");
  a_rw_decode: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
    (state_reg == ST_ACK && ack_next_reg == ST_RD) |-> shift_reg[0])
    else $error("read entered without read bit");
  a_stop_idle: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
    stop_det |=> state_reg == ST_IDLE && !busy_reg && !sda_oe_reg)
    else $error("stop did not free the bus");
  a_irq_release: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (cfg_reg.ctrl[CFG_IRQ_MODE] && !irq_pending_reg) |=> !ninth_oe_reg)
    else $error("interrupt pin driven while idle");

  c_irq: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    irq_pending_reg ##1 rd_event);
  c_addr_ack: cover property (@(posedge i_link_clk) disable iff (i_sys_rst)
    state_reg == ST_ACK && sda_oe_reg);
  c_read: cover property (@(posedge i_link_clk) disable iff (i_sys_rst)
    load_rd);
  c_pwm_wrap: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    osc_tick && pwm_cnt_reg == PWM_LAST);

endmodule

// ### gpio_exp_pkg.sv
// constants, carrier types and address decode for the port expander
// assumes a 100 MHz system clock and a separate serial-bus sampling clock
package gpio_exp_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OSC_PERIOD_NS = 31250;
  localparam int unsigned OSC_DIV       = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [11:0] OSC_DIV_LAST  = 12'(OSC_DIV - 1);
  localparam int unsigned PWM_STEPS     = 240;
  localparam logic [7:0]  PWM_LAST      = 8'(PWM_STEPS - 1);
  localparam logic [7:0]  PWM_FULL      = 8'(PWM_STEPS);

  localparam logic [7:0] REG_INPUT       = 8'h00;
  localparam logic [7:0] REG_PHASE0      = 8'h01;
  localparam logic [7:0] REG_DIR         = 8'h03;
  localparam logic [7:0] REG_PWM_EN      = 8'h04;
  localparam logic [7:0] REG_GLOBAL      = 8'h05;
  localparam logic [7:0] REG_PHASE1      = 8'h09;
  localparam logic [7:0] REG_MASTER      = 8'h0e;
  localparam logic [7:0] REG_CONFIG      = 8'h0f;
  localparam logic [7:0] REG_INTENS_BASE = 8'h10;
  localparam logic [7:0] REG_INTENS_LAST = 8'h13;

  localparam int CFG_BLINK_EN   = 0;
  localparam int CFG_BLINK_FLIP = 1;
  localparam int CFG_GLOBAL     = 2;
  localparam int CFG_IRQ_MODE   = 3;
  localparam int CFG_O8_PH0     = 4;
  localparam int CFG_O8_PH1     = 5;
  localparam logic [7:0] CFG_MASK = 8'h3f;

  typedef struct packed {
    logic [7:0]  phase0;
    logic [7:0]  phase1;
    logic [7:0]  dir;
    logic [7:0]  pwm_en;
    logic [7:0]  glob_duty;
    logic [3:0]  master;
    logic [7:0]  ctrl;
    logic [31:0] intens;
  } cfg_s;

  localparam cfg_s CFG_RST = '{
    phase0: 8'hff, phase1: 8'hff, dir: 8'hff, pwm_en: 8'h00,
    glob_duty: 8'h00, master: 4'hf, ctrl: 8'h08, intens: 32'hffff_ffff};

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WR, ST_ACK, ST_RD, ST_MACK
  } i2c_state_e;

  typedef logic [1:0] pin_class_t;
  localparam pin_class_t PIN_GND = 2'h0;
  localparam pin_class_t PIN_VCC = 2'h1;
  localparam pin_class_t PIN_SDA = 2'h2;
  localparam pin_class_t PIN_SCL = 2'h3;

  // bit 1 of a class marks a bus-tied pin; bit0^bit1 marks vcc or sda
  function automatic logic [6:0] addr_map(input pin_class_t c2,
                                          input pin_class_t c1,
                                          input pin_class_t c0);
    addr_map = {c2[1], ~c1[1], c1[1], c0[1],
                c2[0] ^ c2[1], c1[0] ^ c1[1], c0[0] ^ c0[1]};
  endfunction

endpackage

// ### i2c_master_model.sv
// two-wire bus master model: frames, bytes and acknowledge clocks
// assumes the bench resolves a pulled-up sda wire from all drivers
`timescale 1ns/100ps
module i2c_master_model (
  // bus
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // five link clocks per phase keeps the design's sampler comfortable
  localparam int H = 640;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // master makes every scl pulse, sda moves only while scl low
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    #(H);
    o_scl = 1'b1;
    #(H/2);
    r = i_sda;
    #(H/2);
    o_scl = 1'b0;
    #(H/4);
  endtask
  // start and stop edges with scl high
  task automatic start();
    o_sda = 1'b1;
    #(H);
    o_scl = 1'b1;
    #(H);
    o_sda = 1'b0;
    #(H);
    o_scl = 1'b0;
    // first data bit must not move sda on the scl falling edge
    #(H/4);
  endtask
  task automatic stop();
    o_sda = 1'b0;
    #(H);
    o_scl = 1'b1;
    #(H);
    o_sda = 1'b1;
    #(H);
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(mack, ack);
  endtask
endmodule

// ### i2c_led_gpio_expander_tb.sv
// self-checking bench for the port expander
// assumes the package and the bus master model are compiled first
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  mismatches++; $display("mismatch t=%0t got %h exp %h", $time, a, e); \
  end end
module i2c_led_gpio_expander_tb;
  import gpio_exp_pkg::*;
  localparam logic [6:0] ADDR = 7'h29;
  logic       i_clk = 1'b0, i_link_clk = 1'b0, i_sys_rst = 1'b0;
  logic [7:0] pin_drv = 8'hff, got = 8'h00, e, exp_q[$];
  logic       got_stb = 1'b0;
  int         mismatches = 0, n_compared = 0, seed = 32'hd81d_3540;
  wire logic  scl, m_sda, sda_oe, irq_oe, stby, osc;
  wire logic [7:0] port_oe;
  wire logic  sda = m_sda & ~sda_oe;
  wire logic [7:0] pins = pin_drv & ~port_oe;
  always #5 i_clk = ~i_clk;
  always #62.5 i_link_clk = ~i_link_clk;
  i2c_master_model m_u (.i_sda(sda), .o_scl(scl), .o_sda(m_sda));
  // ad0 tied to sda, others to ground: address 0x29
  i2c_led_gpio_expander dut_u (
    .i_clk(i_clk), .i_link_clk(i_link_clk), .i_sys_rst(i_sys_rst),
    .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .i_addr_select_pin_0(sda), .i_addr_select_pin_1(1'b0),
    .i_addr_select_pin_2(1'b0), .i_io_port_pins(pins),
    .o_io_port_pins_out(), .o_io_port_pins_oe(port_oe),
    .o_irq_or_ninth_output_pin_out(),
    .o_irq_or_ninth_output_pin_oe(irq_oe),
    .o_standby(stby), .o_osc_running(osc));
  always @(got_stb) begin
    e = exp_q.pop_front();
    `CHK(got, e)
  end
  task automatic see(input logic [7:0] act, input logic [7:0] ex);
    exp_q.push_back(ex);
    got = act;
    got_stb = ~got_stb;
    #1;
  endtask
  task automatic put(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    m_u.xfer(d, 1'b1, q, a);
    see({7'h00, a}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    m_u.start();
    put({ADDR, 1'b0});
    put(c);
    put(d);
    m_u.stop();
    repeat (20) @(negedge i_clk);
  endtask
  // command alone then stop only sets the pointer
  task automatic rd(input logic [7:0] c, input logic [7:0] ex);
    logic [7:0] q;
    logic       a;
    m_u.start();
    put({ADDR, 1'b0});
    put(c);
    m_u.stop();
    m_u.start();
    put({ADDR, 1'b1});
    m_u.xfer(8'hff, 1'b1, q, a);
    see(q, ex);
    m_u.stop();
    repeat (20) @(negedge i_clk);
  endtask
  task automatic drive(input logic [7:0] v);
    @(posedge i_clk);
    pin_drv <= v;
    repeat (20) @(negedge i_clk);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #800_000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [7:0] v;
    // a rising reset edge at time zero reaches both clock domains
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (100) @(negedge i_clk);
    see(port_oe, 8'h00);
    see({5'h00, irq_oe, stby, osc}, 8'h02);
    v = 8'($random(seed));
    drive(v);
    rd(REG_INPUT, v);
    drive(v ^ 8'h01);
    see({7'h00, irq_oe}, 8'h01);
    drive(v);
    see({7'h00, irq_oe}, 8'h00);
    drive(v ^ 8'h80);
    rd(REG_INPUT, v ^ 8'h80);
    see({7'h00, irq_oe}, 8'h00);
    $display("test inputs done");
    wr(REG_PHASE0, 8'h5a);
    wr(REG_PHASE1, 8'h0f);
    wr(REG_DIR, 8'h00);
    see(port_oe, 8'ha5);
    rd(REG_INPUT, (v ^ 8'h80) & 8'h5a);
    wr(REG_CONFIG, 8'h09);
    see(port_oe, 8'ha5);
    wr(REG_CONFIG, 8'h0b);
    see(port_oe, 8'hf0);
    wr(REG_CONFIG, 8'h02);
    see(port_oe, 8'ha5);
    see({7'h00, irq_oe}, 8'h01);
    $display("test outputs done");
    wr(REG_PWM_EN, 8'h01);
    see({6'h00, stby, osc}, 8'h01);
    see(port_oe, 8'ha5);
    wr(REG_MASTER, 8'h00);
    see(port_oe, 8'ha4);
    wr(REG_PWM_EN, 8'h00);
    see(port_oe, 8'ha5);
    see({6'h00, stby, osc}, 8'h02);
    $display("test pwm done");
    report_and_stop();
  end
endmodule
